// ### logic/lirc_pkg.sv
// package for local interrupt and reset control
package lirc_pkg;
  localparam int           DATA_W = 32;
  localparam int           VEC_W  = 9;
  // register byte offsets
  localparam logic [7:0]   OFF_CTRL    = 8'h00;
  localparam logic [7:0]   OFF_HOSTLNK = 8'h04;
  localparam logic [7:0]   OFF_EXCSHM  = 8'h08;
  localparam logic [7:0]   OFF_CLKCTL  = 8'h0C;
  localparam logic [7:0]   OFF_VECDMA  = 8'h10;
  localparam logic [7:0]   OFF_VECPPU  = 8'h14;
  localparam logic [7:0]   OFF_STATUS  = 8'h18;
  localparam logic [7:0]   OFF_IDSW    = 8'h1C;
  localparam logic [7:0]   OFF_REGB    = 8'h20;
  localparam logic [7:0]   OFF_REGE    = 8'h24;
  localparam logic [7:0]   OFF_SHBASE  = 8'h28;
  localparam logic [7:0]   OFF_SHSIZE  = 8'h2C;
  localparam logic [7:0]   OFF_PRIRQ   = 8'h30;
  // bit positions
  localparam int           BIT_EXC_EN    = 6;
  localparam int           BIT_RTC_IE    = 6;
  localparam int           BIT_HALT_EN   = 8;
  localparam int           BIT_INIT_EN   = 10;
  localparam int           BIT_HIRQ_EN   = 12;
  localparam int           BIT_HIRQ_LOC  = 13;
  localparam int           BIT_HIRQ_PEND = 14;
  localparam int           BIT_HW_RESET  = 14;
  localparam int           BIT_MB_EN     = 3;
  localparam int           BIT_CTL_SWRST = 0;
  localparam int           BIT_CTL_MMEN  = 1;
  // interrupt vectors, octal values held in hex
  localparam logic [8:0]   VEC_PROG   = 9'h0A0;
  localparam logic [8:0]   VEC_RTC    = 9'h040;
  localparam logic [8:0]   VEC_CTR    = 9'h044;
  localparam logic [8:0]   VEC_MB4    = 9'h050;
  localparam logic [8:0]   VEC_MB8    = 9'h054;
  localparam logic [8:0]   VEC_HACK   = 9'h058;
  localparam logic [8:0]   VEC_MB12   = 9'h05C;
  localparam logic [8:0]   VEC_DMA0   = 9'h094;
  localparam logic [8:0]   VEC_DMA1   = 9'h098;
  localparam logic [8:0]   VEC_PPU0   = 9'h080;
  localparam logic [8:0]   VEC_PPU1   = 9'h084;
  localparam logic [8:0]   VEC_PPU2   = 9'h088;
  localparam logic [8:0]   VEC_CRX    = 9'h030;
  localparam logic [8:0]   VEC_CTX    = 9'h034;
  localparam logic [8:0]   VEC_MPSL   = 9'h038;
  localparam logic [15:0]  SPEC_PC    = 16'hF604;
  localparam logic [15:0]  SPEC_PSW   = 16'h00E0;
  localparam logic [15:0]  COLD_PC    = 16'hF600;
  // source indices in grant order
  localparam int           NSRC = 14;
  localparam logic [2:0]   PRI_RTC = 3'h6;
  localparam int           RST_CYC = 4;
  localparam logic [2:0]   RST_LEN = 3'h4;
  typedef struct packed {
    logic       valid;
    logic [2:0] level;
    logic [8:0] vector;
  } lirc_grant_type;
  typedef struct packed {
    logic consoleInit;
    logic consoleTest;
    logic dmaStrobes;
    logic ppuStrobes;
    logic cpuInit;
    logic mpslReset;
  } lirc_rst_type;
endpackage

// ### logic/lirc_top.sv
// local interrupt priority, special interrupt and reset distribution
`timescale 1ns/1ps
// How it works
// - sources request, processor acknowledges, block drives granted vector.
// - dma unit and parallel port share one daisy-chained line, dma first.
// - parallel port answers acknowledge only with no dma request pending.
// - program irq programmable, vector 240; clock 100 beats counter 104.
// - level 5 order: mailbox 120, 124, host ack 130, mailbox 134.
// - level 4 order: dma, parallel port, console rx 60, tx 64, serial 70.
// - dma vectors default 224/230, parallel port 200/204/210, programmable.
// - exception enable: mailbox word0 write or power-good loss raises special.
// - exception enable plus host halt and link bit 8 raises special.
// - exception enable plus host init and link bit 10 raises special.
// - special forces pc 173004, psw 340, clears exception enable.
// - reset instruction gives software reset; power-up gives hardware reset.
// - software reset asserts console serial initialise input.
// - both resets pulse dma and parallel port strobes together.
// - software reset disables memory management, leaves link, lamps and vector registers alone.
// - both resets clear clock interrupt enable and pending interrupts.
// - software reset clears whole exception/shared-memory register.
// - hardware reset on power when id switches are zero, else host dc-ok; or mailbox word0 bit 14 write.
// - hardware reset asserts console test, cpu init, serial chip reset.
// - jumper picks firmware at 173000 or console debugger after reset.
// - hardware reset clears control registers and exception register.
// - hardware reset lights all lamps, loads identity switches into reg c.
// - mailbox 4/8/12 writes interrupt only when link bits 6:3 allow.
// - host irq write with link bit 12 sets pending (status bit 0); host ack clears it, posts 130 if bit 13.
module lirc_top
  import lirc_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               rtcTick,
  input  wire logic               ctrTimerIrq,
  input  wire logic [1:0]         dmaIrq,
  input  wire logic [2:0]         ppuIrq,
  input  wire logic               consoleRxIrq,
  input  wire logic               consoleTxIrq,
  input  wire logic               mpslIrq,
  input  wire logic               mbWord0Wr,
  input  wire logic [15:0]        mbWord0Data,
  input  wire logic [2:0]         mbWordWr,
  input  wire logic               hostIrqWr,
  input  wire logic               hostIrqAck,
  input  wire logic               powerGood,
  input  wire logic               hostHalt,
  input  wire logic               hostInit,
  input  wire logic               hostDcOk,
  input  wire logic               powerDetect,
  input  wire logic               resetInstr,
  input  wire logic               cpuAck,
  input  wire logic               debugJumper,
  input  wire logic [7:0]         idSwitch,
  output lirc_grant_type          irqGrant,
  output logic [8:0]              ackVector,
  output logic                    specialIrq,
  output logic [15:0]             forcePc,
  output logic [15:0]             forcePsw,
  output logic                    bootDebugger,
  output logic [15:0]             bootPc,
  output lirc_rst_type            rstOut,
  output logic                    mmEnable,
  output logic [7:0]              lampsOut,
  output logic                    hostBusIrq
);
  logic        awHeld_q, wHeld_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        doWr, doRd;
  logic [15:0] hostLink_q, excShm_q, clkCtl_q, regB_q, regE_q, shBase_q, shSize_q;
  logic [7:0]  idReg_q, lamps_q;
  logic [17:0] vecDma_q;
  logic [26:0] vecPpu_q;
  logic [2:0]  prLevel_q;
  logic        prReq_q, mmEn_q;
  logic [NSRC-1:0] pend_q, srcSet;
  logic [8:0]  srcVec [NSRC];
  logic [2:0]  srcLvl [NSRC];
  logic        swRst, hwRst, hwReq;
  logic [2:0]  hwCnt_q, swCnt_q;
  logic        hostIrqPend_q;
  logic        specialEv, ppuBlocked, progWins;
  logic [3:0]  winIdx;
  logic        winValid;
  logic        writeCtrl;

  // bus slave: accept address and data in either order
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWr) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWr) begin
        wHeld_q <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
  assign doWr = awHeld_q && wHeld_q;
  assign doRd = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !s_axi_rvalid;
  assign writeCtrl = doWr && wStrb_q[0];

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (doWr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddr_q[7:2] > OFF_PRIRQ[7:2]) ? 2'h2 : 2'h0;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic [31:0] rdMux(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      OFF_HOSTLNK: r = {16'h0000, hostLink_q};
      OFF_EXCSHM:  r = {16'h0000, excShm_q};
      OFF_CLKCTL:  r = {16'h0000, clkCtl_q};
      OFF_VECDMA:  r = {14'h0000, vecDma_q};
      OFF_VECPPU:  r = {5'h00, vecPpu_q};
      OFF_STATUS:  r = {16'h0000, pend_q, mmEn_q, hostIrqPend_q};
      OFF_IDSW:    r = {24'h000000, idReg_q};
      OFF_REGB:    r = {16'h0000, regB_q};
      OFF_REGE:    r = {16'h0000, regE_q};
      OFF_SHBASE:  r = {16'h0000, shBase_q};
      OFF_SHSIZE:  r = {16'h0000, shSize_q};
      OFF_PRIRQ:   r = {28'h0000000, prReq_q, prLevel_q};
      default:     r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (doRd) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux(s_axi_araddr);
      s_axi_rresp  <= (s_axi_araddr[7:2] > OFF_PRIRQ[7:2]) ? 2'h2 : 2'h0;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign swRst = resetInstr || (writeCtrl && awAddr_q == OFF_CTRL && wData_q[BIT_CTL_SWRST]);
  // hardware reset causes: standalone power, dc-ok, word0 bit 14
  assign hwReq = (idSwitch == 8'h00 ? powerDetect : hostDcOk)
               || (mbWord0Wr && mbWord0Data[BIT_HW_RESET]);
  assign hwRst = hwReq || !nrst;

  // stretched reset outputs
  always_ff @(posedge clk_sys) begin
    if (!nrst || hwReq) begin
      hwCnt_q <= RST_LEN;
    end else if (hwCnt_q != 3'h0) begin
      hwCnt_q <= hwCnt_q - 3'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      swCnt_q <= 3'h0;
    end else if (swRst) begin
      swCnt_q <= RST_LEN;
    end else if (swCnt_q != 3'h0) begin
      swCnt_q <= swCnt_q - 3'h1;
    end
  end
  assign rstOut.consoleInit = swCnt_q != 3'h0;
  // hardware reset drives console test, cpu init, serial reset
  assign rstOut.consoleTest = hwCnt_q != 3'h0;
  assign rstOut.cpuInit     = hwCnt_q != 3'h0;
  assign rstOut.mpslReset   = hwCnt_q != 3'h0;
  assign rstOut.dmaStrobes  = (hwCnt_q != 3'h0) || (swCnt_q != 3'h0);
  assign rstOut.ppuStrobes  = (hwCnt_q != 3'h0) || (swCnt_q != 3'h0);

  assign bootDebugger = debugJumper;
  assign bootPc       = COLD_PC;

  assign specialEv = excShm_q[BIT_EXC_EN] && (mbWord0Wr || !powerGood
                   || (hostHalt && hostLink_q[BIT_HALT_EN])
                   || (hostInit && hostLink_q[BIT_INIT_EN]));

  // control registers
  always_ff @(posedge clk_sys) begin
    if (hwRst) begin
      hostLink_q <= 16'h0000;
      regB_q     <= 16'h0000;
      regE_q     <= 16'h0000;
      excShm_q   <= 16'h0000;
      clkCtl_q   <= 16'h0000;
      mmEn_q     <= 1'b0;
      prReq_q    <= 1'b0;
      prLevel_q  <= 3'h0;
      vecDma_q   <= {VEC_DMA1, VEC_DMA0};
      vecPpu_q   <= {VEC_PPU2, VEC_PPU1, VEC_PPU0};
    end else begin
      if (writeCtrl && awAddr_q == OFF_HOSTLNK) hostLink_q <= wData_q[15:0];
      if (writeCtrl && awAddr_q == OFF_REGB) regB_q <= wData_q[15:0];
      if (writeCtrl && awAddr_q == OFF_REGE) regE_q <= wData_q[15:0];
      if (writeCtrl && awAddr_q == OFF_PRIRQ) begin
        prReq_q   <= wData_q[3];
        prLevel_q <= wData_q[2:0];
      end
      if (writeCtrl && awAddr_q == OFF_VECDMA) vecDma_q <= wData_q[17:0];
      if (writeCtrl && awAddr_q == OFF_VECPPU) vecPpu_q <= wData_q[26:0];
      // special clears exception enable; sw reset clears register
      if (swRst) begin
        excShm_q <= 16'h0000;
      end else if (specialEv) begin
        excShm_q[BIT_EXC_EN] <= 1'b0;
      end else if (writeCtrl && awAddr_q == OFF_EXCSHM) begin
        excShm_q <= wData_q[15:0];
      end
      // clock interrupt enable cleared on reset
      if (swRst) begin
        clkCtl_q[BIT_RTC_IE] <= 1'b0;
      end else if (writeCtrl && awAddr_q == OFF_CLKCTL) begin
        clkCtl_q <= wData_q[15:0];
      end
      // memory management off on software reset
      if (swRst) begin
        mmEn_q <= 1'b0;
      end else if (writeCtrl && awAddr_q == OFF_CTRL) begin
        mmEn_q <= wData_q[BIT_CTL_MMEN];
      end
    end
  end

  // shared-memory window left unreset on purpose
  always_ff @(posedge clk_sys) begin
    if (writeCtrl && awAddr_q == OFF_SHBASE) shBase_q <= wData_q[15:0];
    if (writeCtrl && awAddr_q == OFF_SHSIZE) shSize_q <= wData_q[15:0];
  end

  always_ff @(posedge clk_sys) begin
    if (hwRst) begin
      lamps_q <= 8'hFF;
      idReg_q <= 8'h00;
    end else begin
      if (hwCnt_q == 3'h1) idReg_q <= idSwitch;
      if (writeCtrl && awAddr_q == OFF_CTRL) lamps_q <= wData_q[15:8];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (hwRst) begin
      hostIrqPend_q <= 1'b0;
    end else if (hostIrqWr && hostLink_q[BIT_HIRQ_EN]) begin
      hostIrqPend_q <= 1'b1;
    end else if (hostIrqAck) begin
      hostIrqPend_q <= 1'b0;
    end
  end

  // source table in grant order
  assign srcSet = {
    mpslIrq, consoleTxIrq, consoleRxIrq, ppuIrq[2], ppuIrq[1], ppuIrq[0], dmaIrq[1], dmaIrq[0],
    // mailbox interrupts gated by link enables
    mbWordWr[2] && (&hostLink_q[6:BIT_MB_EN]),
    // acknowledge posts local interrupt when bit 13 set
    hostIrqAck && hostIrqPend_q && hostLink_q[BIT_HIRQ_LOC],
    mbWordWr[1] && (&hostLink_q[6:BIT_MB_EN]),
    mbWordWr[0] && (&hostLink_q[6:BIT_MB_EN]),
    ctrTimerIrq,
    rtcTick && clkCtl_q[BIT_RTC_IE]};
  assign srcVec = '{VEC_RTC, VEC_CTR, VEC_MB4, VEC_MB8, VEC_HACK, VEC_MB12,
                    vecDma_q[8:0], vecDma_q[17:9], vecPpu_q[8:0], vecPpu_q[17:9], vecPpu_q[26:18],
                    VEC_CRX, VEC_CTX, VEC_MPSL};
  assign srcLvl = '{PRI_RTC, PRI_RTC, 3'h5, 3'h5, 3'h5, 3'h5, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4,
                    3'h4, 3'h4, 3'h4};

  // parallel port blocked while dma pending
  assign ppuBlocked = pend_q[6] || pend_q[7];

  // first pending entry wins; table already ordered by level
  always_comb begin
    winIdx   = 4'h0;
    winValid = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      // daisy chain: ppu skipped when dma pending
      if (pend_q[i] && !((i >= 8 && i <= 10) && ppuBlocked)) begin
        winIdx   = 4'(i);
        winValid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (hwRst || swRst) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q | srcSet) & ~(((NSRC)'(cpuAck && winValid && !progWins) << winIdx) & ~srcSet);
    end
  end

  // grant with program irq at its own level
  assign progWins = prReq_q && (!winValid || prLevel_q >= srcLvl[winIdx]);
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irqGrant  <= '0;
      ackVector <= 9'h000;
    end else begin
      if (progWins) begin
        irqGrant <= '{valid: 1'b1, level: prLevel_q, vector: VEC_PROG};
      end else begin
        irqGrant <= '{valid: winValid, level: srcLvl[winIdx], vector: srcVec[winIdx]};
      end
      if (cpuAck) ackVector <= irqGrant.vector;
    end
  end

  // forced pc and psw on special
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      specialIrq <= 1'b0;
      forcePc    <= 16'h0000;
      forcePsw   <= 16'h0000;
    end else begin
      specialIrq <= specialEv;
      forcePc    <= SPEC_PC;
      forcePsw   <= SPEC_PSW;
    end
  end

  assign mmEnable   = mmEn_q;
  assign lampsOut   = lamps_q;
  assign hostBusIrq = hostIrqPend_q;
endmodule

// ### tb/lirc_asserts.sv
// checker for grant, special interrupt and reset outputs of lirc_top
`timescale 1ns/1ps
module lirc_asserts
  import lirc_pkg::*;
(
  input wire logic           clk_sys,
  input wire logic           nrst,
  input wire logic           resetInstr,
  input wire logic           cpuAck,
  input wire logic           hostIrqAck,
  input wire logic           hostIrqWr,
  input wire logic           mbWord0Wr,
  input wire logic           powerGood,
  input wire logic           hostHalt,
  input wire logic           hostInit,
  input wire logic           debugJumper,
  input wire lirc_grant_type irqGrant,
  input wire logic [8:0]     ackVector,
  input wire logic           specialIrq,
  input wire logic [15:0]    forcePc,
  input wire logic [15:0]    forcePsw,
  input wire logic           bootDebugger,
  input wire logic [15:0]    bootPc,
  input wire lirc_rst_type   rstOut,
  input wire logic [7:0]     lampsOut,
  input wire logic           hostBusIrq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence sw_pulse_s;
    rstOut.consoleInit [*4] ##1 !rstOut.consoleInit;
  endsequence
  sequence hw_group_s;
    rstOut.consoleTest && rstOut.cpuInit && rstOut.mpslReset && rstOut.dmaStrobes;
  endsequence
  chk_special_entry: assert property (specialIrq |-> forcePc == SPEC_PC && forcePsw == SPEC_PSW)
    else $error("special entry values wrong");
  chk_special_cause: assert property ($rose(specialIrq) |-> $past(mbWord0Wr || !powerGood || hostHalt || hostInit))
    else $error("special raised without cause");
  chk_sw_start: assert property (resetInstr |-> ##[1:2] rstOut.consoleInit && rstOut.ppuStrobes)
    else $error("software reset outputs missing");
  chk_sw_length: assert property ($rose(rstOut.consoleInit) |-> sw_pulse_s)
    else $error("console init pulse length wrong");
  chk_strobe_pair: assert property (rstOut.dmaStrobes == rstOut.ppuStrobes)
    else $error("dma and parallel strobes differ");
  chk_hw_group: assert property (rstOut.consoleTest |-> hw_group_s)
    else $error("hardware reset outputs incomplete");
  chk_lamps_on: assert property ($fell(rstOut.consoleTest) |-> lampsOut == 8'hFF)
    else $error("lamps not all on after hardware reset");
  chk_boot_select: assert property (bootPc == COLD_PC && bootDebugger == debugJumper)
    else $error("boot selection wrong");
  chk_ack_vector: assert property (cpuAck && irqGrant.valid |=> ackVector == $past(irqGrant.vector))
    else $error("acknowledge vector differs from grant");
  chk_host_ack: assert property (hostIrqAck && !hostIrqWr |=> !hostBusIrq)
    else $error("host irq pending not cleared by ack");
endmodule
bind lirc_top lirc_asserts u_lirc_asserts (.*);

// ### tb/lirc_cpu_model.sv
// processor core model: acknowledges each granted interrupt after a delay
`timescale 1ns/1ps
module lirc_cpu_model
  import lirc_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           nrst,
  input  wire lirc_grant_type irqGrant,
  input  wire logic [3:0]     ackDelay,
  output logic                cpuAck
);
  logic [4:0] waitCnt_q;
  always_ff @(posedge clk_sys) begin
    if (!nrst || cpuAck || !irqGrant.valid) begin
      waitCnt_q <= '0;
      cpuAck    <= '0;
    end else if (waitCnt_q > {1'h0, ackDelay}) begin
      cpuAck <= 1'h1;
    end else begin
      waitCnt_q <= waitCnt_q + 5'h1;
    end
  end
endmodule

// ### tb/test_local_interrupt_reset_control.sv
// self-checking bench for local interrupt and reset control
`timescale 1ns/1ps
module test_local_interrupt_reset_control
  import lirc_pkg::*;
;
  logic           clk_sys = '0, nrst = '0, powerGood = '1, cpuAck, ackSeen = '0;
  logic [7:0]     s_axi_awaddr = '0, s_axi_araddr = '0, idSwitch = '0, lampsOut;
  logic [31:0]    s_axi_wdata = '0, s_axi_rdata, rnd = 32'h0000E9CD, rd;
  logic [3:0]     s_axi_wstrb = 4'hF, ackDelay = '0;
  logic           s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic           rtcTick = '0, ctrTimerIrq = '0, consoleRxIrq = '0, consoleTxIrq = '0, mpslIrq = '0;
  logic [1:0]     dmaIrq = '0, s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]     ppuIrq = '0, mbWordWr = '0;
  logic           mbWord0Wr = '0, hostIrqWr = '0, hostIrqAck = '0, hostHalt = '0, hostInit = '0;
  logic           hostDcOk = '0, powerDetect = '0, resetInstr = '0, debugJumper = '0;
  logic [15:0]    mbWord0Data = '0, forcePc, forcePsw, bootPc;
  logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic           specialIrq, bootDebugger, mmEnable, hostBusIrq;
  lirc_grant_type irqGrant;
  lirc_rst_type   rstOut;
  logic [8:0]     ackVector, v0, v1, expQ[$];
  int             errors = 0, testsRun = 0, cycles = 0;

  always #2.5 clk_sys = ~clk_sys;

  lirc_top u_lirc_top (.*);
  lirc_cpu_model u_lirc_cpu_model (.clk_sys(clk_sys), .nrst(nrst), .irqGrant(irqGrant), .ackDelay(ackDelay),
                                   .cpuAck(cpuAck));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic print_verdict;
    $display("counts: %0d comparisons, %0d mismatches", testsRun, errors);
    if (errors == 0 && testsRun > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  // bus master write: address and data offered together, released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = '0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    while (!b) begin
      @(negedge clk_sys);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      @(posedge clk_sys);
      if (aw) s_axi_awvalid <= '0;
      if (w) s_axi_wvalid <= '0;
    end
    s_axi_bready <= '0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, got;
    got = '0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    while (!got) begin
      @(negedge clk_sys);
      ar = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (ar) s_axi_arvalid <= '0;
    end
    s_axi_rready <= '0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axr(a, rd, rsp);
    check(what, e, rd & m);
  endtask

  // one-cycle pulse on the local sources and host mailbox strobes
  task automatic fire(input logic [13:0] m);
    @(posedge clk_sys);
    {mpslIrq, consoleTxIrq, consoleRxIrq, ppuIrq, dmaIrq, hostIrqAck, mbWordWr, ctrTimerIrq, rtcTick} <= m;
    @(posedge clk_sys);
    {mpslIrq, consoleTxIrq, consoleRxIrq, ppuIrq, dmaIrq, hostIrqAck, mbWordWr, ctrTimerIrq, rtcTick} <= '0;
  endtask

  task automatic drain;
    int n;
    n = 0;
    while (expQ.size() != 0 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    check("acks outstanding", 32'h0, expQ.size());
    tick(4);
  endtask

  // compares each acknowledged vector with the oldest expected one
  always @(negedge clk_sys) begin
    if (ackSeen && expQ.size() == 0) check("unexpected ack", 32'h0, {23'h0, ackVector});
    else if (ackSeen) check("ack vector", {23'h0, expQ.pop_front()}, {23'h0, ackVector});
    ackSeen = cpuAck;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("BAD timeout expected done seen hang");
      print_verdict();
    end
  end

  initial begin
    rnd = xs(rnd);
    idSwitch <= rnd[7:0] | 8'h01;
    tick(2);
    nrst <= '1;
    debugJumper <= '1;
    tick(8);
    check("lamps", 32'hFF, {24'h0, lampsOut});
    check("boot", {15'h0, COLD_PC, 1'h1}, {15'h0, bootPc, bootDebugger});
    rdchk("id switch reg", OFF_IDSW, 32'hFF, {24'h0, idSwitch});
    rdchk("exception reg", OFF_EXCSHM, 32'hFFFF, 32'h0);
    axr(8'h40, rd, rsp);
    check("unmapped resp", 32'h2, {30'h0, rsp});
    $display("test reset values done");
    rnd = xs(rnd);
    ackDelay <= rnd[3:0];
    axw(OFF_CLKCTL, 32'h40);
    expQ = '{VEC_RTC, VEC_CTR, VEC_DMA0, VEC_PPU0, VEC_CRX, VEC_CTX, VEC_MPSL};
    fire(14'h3943);
    drain();
    $display("test level priority done");
    axw(OFF_HOSTLNK, 32'h3078);
    @(posedge clk_sys);
    hostIrqWr <= '1;
    @(posedge clk_sys);
    hostIrqWr <= '0;
    tick(2);
    check("host irq pending", 32'h1, {31'h0, hostBusIrq});
    expQ = '{VEC_MB4, VEC_MB8, VEC_HACK, VEC_MB12};
    fire(14'h003C);
    drain();
    check("host irq cleared", 32'h0, {31'h0, hostBusIrq});
    axw(OFF_HOSTLNK, 32'h3070);
    fire(14'h001C);
    tick(30);
    rdchk("masked pending", OFF_STATUS, 32'hFFFC, 32'h0);
    $display("test mailbox done");
    rnd = xs(rnd);
    v0 = {1'h1, rnd[7:2], 2'h0};
    v1 = {1'h1, rnd[15:10], 2'h0};
    ackDelay <= rnd[19:16];
    axw(OFF_VECDMA, {14'h0, v1, v0});
    expQ = '{v0, v1, VEC_PPU0, VEC_PPU1, VEC_PPU2};
    fire(14'h07C0);
    drain();
    $display("test daisy chain done");
    for (int k = 0; k < 4; k++) begin
      axw(OFF_HOSTLNK, 32'h0500);
      axw(OFF_EXCSHM, 32'h40);
      @(posedge clk_sys);
      {hostInit, hostHalt, powerGood, mbWord0Wr} <= {k == 3, k == 2, k != 1, k == 0};
      @(posedge clk_sys);
      {hostInit, hostHalt, powerGood, mbWord0Wr} <= 4'h2;
      #1;
      check("special raised", 32'h1, {31'h0, specialIrq});
      check("special entry", {SPEC_PC, SPEC_PSW}, {forcePc, forcePsw});
      rdchk("enable cleared", OFF_EXCSHM, 32'h40, 32'h0);
    end
    $display("test special interrupt done");
    ackDelay <= 4'hF;
    axw(OFF_CTRL, 32'h0002);
    #1;
    check("mm enabled", 32'h1, {31'h0, mmEnable});
    axw(OFF_PRIRQ, 32'hF);
    #1;
    check("program irq grant", {19'h0, 1'h1, 3'h7, VEC_PROG}, {19'h0, irqGrant});
    axw(OFF_PRIRQ, 32'h0);
    axw(OFF_EXCSHM, 32'h40);
    axw(OFF_CLKCTL, 32'h40);
    fire(14'h0040);
    @(posedge clk_sys);
    resetInstr <= '1;
    @(posedge clk_sys);
    resetInstr <= '0;
    tick(1);
    #1;
    check("sw reset outputs", 32'h7, {rstOut.consoleInit, rstOut.dmaStrobes, rstOut.ppuStrobes});
    tick(30);
    check("mm disabled", 32'h0, {31'h0, mmEnable});
    check("lamps kept", 32'h0, {24'h0, lampsOut});
    rdchk("exception cleared", OFF_EXCSHM, 32'hFFFF, 32'h0);
    rdchk("clock ie cleared", OFF_CLKCTL, 32'h40, 32'h0);
    rdchk("link kept", OFF_HOSTLNK, 32'h3FFF, 32'h0500);
    rdchk("pending dropped", OFF_STATUS, 32'hFFFC, 32'h0);
    $display("test software reset done");
    for (int k = 0; k < 2; k++) begin
      axw(OFF_CTRL, 32'h0);
      axw(OFF_HOSTLNK, 32'h0500);
      @(posedge clk_sys);
      mbWord0Data <= 16'h4000;
      mbWord0Wr <= (k == 0);
      hostDcOk <= (k == 1);
      @(posedge clk_sys);
      mbWord0Wr <= '0;
      hostDcOk <= '0;
      tick(1);
      #1;
      check("hw reset outputs", 32'h7, {rstOut.consoleTest, rstOut.cpuInit, rstOut.mpslReset});
      tick(8);
      check("lamps on", 32'hFF, {24'h0, lampsOut});
      rdchk("link cleared", OFF_HOSTLNK, 32'hFFFF, 32'h0);
    end
    $display("test hardware reset done");
    print_verdict();
  end
endmodule
